//--- common/counter_pkg.sv
`default_nettype none

package counter_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_COUNTERS = 8;
  localparam int COUNT_W      = 32;
  localparam int NUM_ROUTED   = 8;
  localparam int POOL_W       = 16;
  localparam int SEL_W        = 4;
  localparam int FIFO_DEPTH   = 16;

  // ==========================================================
  // register offsets inside one counter's 32-byte window
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_ROUTE  = 5'h04;
  localparam logic [4:0] OFF_INIT   = 5'h08;
  localparam logic [4:0] OFF_RELOAD = 5'h0C;
  localparam logic [4:0] OFF_COUNT  = 5'h10;
  localparam logic [4:0] OFF_FIFO   = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  localparam logic [4:0] OFF_AUX    = 5'h1C;

  // ==========================================================
  // reset values and limits
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] ROUTE_RST  = 32'h0000_0000;
  localparam logic [31:0] INIT_RST   = 32'h0000_0000;
  localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
  localparam logic [31:0] COUNT_MAX  = 32'hFFFF_FFFF;
  localparam logic [31:0] COUNT_MIN  = 32'h0000_0000;

  // ==========================================================
  // status bit positions
  localparam int ST_RUNNING  = 0;
  localparam int ST_ARMED    = 1;
  localparam int ST_OVERFLOW = 2;
  localparam int ST_TC_OUT   = 3;
  localparam int ST_LEVEL_LO = 8;

  // ==========================================================
  // modes and fields
  typedef enum logic [1:0] {
    MODE_ON_DEMAND = 2'b00,
    MODE_SAMPLE    = 2'b01,
    MODE_PULSE     = 2'b10,
    MODE_RESERVED  = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    DIR_UP       = 2'b00,
    DIR_DOWN     = 2'b01,
    DIR_EXTERNAL = 2'b10,
    DIR_RESERVED = 2'b11
  } dir_e;

  typedef struct packed {
    logic [14:0] unused;
    logic        timebase_ext;
    logic        sample_edge;
    logic        toggle_idle;
    logic        tc_polarity;
    logic        tc_toggle;
    logic        reset_edge;
    logic        count_reset_enable;
    logic        pause_level_select;
    logic        pause_enable;
    logic        arm_edge_select;
    logic        arm_enable;
    dir_e        direction_select;
    logic        active_edge_select;
    mode_e       mode;
    logic        run;
  } ctrl_s;

  typedef struct packed {
    logic [3:0]       unused;
    logic [SEL_W-1:0] timebase;
    logic [SEL_W-1:0] sample_clock;
    logic [SEL_W-1:0] reset_src;
    logic [SEL_W-1:0] pause_src;
    logic [SEL_W-1:0] arm_src;
    logic [SEL_W-1:0] direction_input_select;
    logic [SEL_W-1:0] measured;
  } route_s;

endpackage

`default_nettype wire

//--- core/sample_fifo.sv
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire logic                       flush,
  // filling side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // draining side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      level
);

  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      level <= level + LW'(push) - LW'(pop);
    end
  end

endmodule

`default_nettype wire

//--- core/edge_counter_32.sv
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none

module edge_counter_32 #(
  parameter int DEPTH = counter_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                               clock,
  input  wire logic                               sys_rst,
  // avalon-mm slave
  input  wire logic [7:0]                         avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [31:0]                        avs_writedata,
  input  wire logic [3:0]                         avs_byteenable,
  output logic [31:0]                             avs_readdata,
  output logic                                    avs_waitrequest,
  // routed signals and exported terminal count
  input  wire logic [counter_pkg::NUM_ROUTED-1:0] routed_in,
  output logic [counter_pkg::NUM_COUNTERS-1:0]    tc_out
);
  import counter_pkg::*;

  localparam int N  = NUM_COUNTERS;
  localparam int LW = $clog2(DEPTH+1);

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic pick_edge(input logic [POOL_W-1:0] rise,
                                     input logic [POOL_W-1:0] fall,
                                     input logic [SEL_W-1:0]  sel,
                                     input logic              falling);
    return falling ? fall[sel] : rise[sel];
  endfunction

  // ==========================================================
  // state
  ctrl_s             ctrl    [N];
  route_s            route   [N];
  logic [31:0]       init_v  [N];
  logic [31:0]       reload  [N];
  logic [31:0]       count   [N];
  logic [31:0]       aux     [N];
  logic [31:0]       next_count [N];
  logic [31:0]       fifo_in [N];
  logic [31:0]       fifo_out[N];
  logic [LW-1:0]     fifo_lvl[N];
  logic [N-1:0]      run_q;
  logic [N-1:0]      armed;
  logic [N-1:0]      overflow;
  logic [N-1:0]      pulse_seen;
  logic [N-1:0]      step;
  logic [N-1:0]      count_up;
  logic [N-1:0]      start;
  logic [N-1:0]      push;
  logic [N-1:0]      fifo_ready;
  logic [N-1:0]      fifo_valid;
  logic [N-1:0]      pop;
  logic [N-1:0]      terminal_count_pulse;
  logic [NUM_ROUTED-1:0] sync1;
  logic [NUM_ROUTED-1:0] sync2;
  logic [POOL_W-1:0] pool;
  logic [POOL_W-1:0] pool_q;
  logic [POOL_W-1:0] rise;
  logic [POOL_W-1:0] fall;
  logic              req;
  logic              done;
  logic [2:0]        chan;
  logic [4:0]        offs;
  logic [31:0]       next_readdata;

  // ==========================================================
  // input synchroniser and signal pool
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= routed_in;
      sync2 <= sync1;
    end
  end

  // terminal counts join the pool so one counter can drive another
  assign pool = {terminal_count_pulse, sync2};
  assign rise = pool & ~pool_q;
  assign fall = ~pool & pool_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pool_q <= '0;
    end
    else
    begin
      pool_q <= pool;
    end
  end

  // ==========================================================
  // avalon slave: one wait state per access
  assign req  = avs_read || avs_write;
  assign done = req && !avs_waitrequest;
  assign chan = avs_address[7:5];
  assign offs = avs_address[4:0];

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  always_comb
  begin
    next_readdata = '0;
    unique case (offs)
      OFF_CTRL:   next_readdata = ctrl[chan];
      OFF_ROUTE:  next_readdata = route[chan];
      OFF_INIT:   next_readdata = init_v[chan];
      OFF_RELOAD: next_readdata = reload[chan];
      OFF_COUNT:  next_readdata = count[chan];
      OFF_FIFO:   next_readdata = fifo_valid[chan] ? fifo_out[chan] : '0;
      OFF_STATUS:
      begin
        next_readdata[ST_RUNNING]  = run_q[chan];
        next_readdata[ST_ARMED]    = armed[chan];
        next_readdata[ST_OVERFLOW] = overflow[chan];
        next_readdata[ST_TC_OUT]   = tc_out[chan];
        next_readdata[ST_LEVEL_LO +: LW] = fifo_lvl[chan];
      end
      OFF_AUX:    next_readdata = aux[chan];
      default:    next_readdata = '0;
    endcase
  end

  // read data stands from the edge that ends the wait state
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      avs_readdata <= '0;
    end
    else if (avs_read && avs_waitrequest)
    begin
      avs_readdata <= next_readdata;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock)
  begin
    for (int k = 0; k < N; k++)
    begin
      if (sys_rst)
      begin
        ctrl[k]   <= ctrl_s'(CTRL_RST);
        route[k]  <= route_s'(ROUTE_RST);
        init_v[k] <= INIT_RST;
        reload[k] <= RELOAD_RST;
      end
      else if (done && avs_write && chan == 3'(k))
      begin
        unique case (offs)
          OFF_CTRL:
            ctrl[k] <= ctrl_s'(merge(ctrl[k], avs_writedata,
                                     avs_byteenable));
          OFF_ROUTE:
            route[k] <= route_s'(merge(route[k], avs_writedata,
                                       avs_byteenable));
          OFF_INIT:
            init_v[k] <= merge(init_v[k], avs_writedata, avs_byteenable);
          OFF_RELOAD:
            reload[k] <= merge(reload[k], avs_writedata, avs_byteenable);
          default:
          begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // per-counter edge, direction and pause decoding
  always_comb
  begin
    for (int k = 0; k < N; k++)
    begin
      start[k] = ctrl[k].run && !run_q[k];
      unique case (ctrl[k].direction_select)
        DIR_DOWN:     count_up[k] = 1'b0;
        DIR_EXTERNAL: count_up[k] = pool[route[k].direction_input_select];
        default:      count_up[k] = 1'b1;
      endcase
      step[k] = ctrl[k].run && run_q[k] && armed[k]
              && ctrl[k].mode != MODE_PULSE
              && !(ctrl[k].pause_enable
                   && pool[route[k].pause_src]
                      == ctrl[k].pause_level_select)
              && pick_edge(rise, fall, route[k].measured,
                           ctrl[k].active_edge_select);
      // natural 32-bit overflow gives the wrap in both directions
      next_count[k] = count_up[k] ? count[k] + 32'h0000_0001
                                  : count[k] - 32'h0000_0001;
    end
  end

  // ==========================================================
  // run tracking and arm-start
  always_ff @(posedge clock)
  begin
    for (int k = 0; k < N; k++)
    begin
      if (sys_rst)
      begin
        run_q[k] <= 1'b0;
        armed[k] <= 1'b0;
      end
      else
      begin
        run_q[k] <= ctrl[k].run;
        if (start[k])
        begin
          armed[k] <= !ctrl[k].arm_enable;
        end
        else if (!ctrl[k].run)
        begin
          armed[k] <= 1'b0;
        end
        else if (ctrl[k].arm_enable
                 && pick_edge(rise, fall, route[k].arm_src,
                              ctrl[k].arm_edge_select))
        begin
          armed[k] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // main count
  always_ff @(posedge clock)
  begin
    for (int k = 0; k < N; k++)
    begin
      if (sys_rst)
      begin
        count[k] <= '0;
      end
      else if (start[k])
      begin
        count[k] <= init_v[k];
      end
      else if (!ctrl[k].run)
      begin
        count[k] <= '0;
      end
      else if (ctrl[k].count_reset_enable
               && pick_edge(rise, fall, route[k].reset_src,
                            ctrl[k].reset_edge))
      begin
        count[k] <= reload[k];
      end
      else if (step[k])
      begin
        count[k] <= next_count[k];
      end
    end
  end

  // ==========================================================
  // terminal count, internal pulse and exported output
  always_ff @(posedge clock)
  begin
    for (int k = 0; k < N; k++)
    begin
      if (sys_rst)
      begin
        terminal_count_pulse[k] <= 1'b0;
      end
      else
      begin
        terminal_count_pulse[k] <= step[k]
          && (count_up[k] ? next_count[k] == COUNT_MAX
                          : next_count[k] == COUNT_MIN);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    for (int k = 0; k < N; k++)
    begin
      if (sys_rst)
      begin
        tc_out[k] <= 1'b0;
      end
      else if (ctrl[k].tc_toggle)
      begin
        if (start[k] || !ctrl[k].run)
        begin
          tc_out[k] <= ctrl[k].toggle_idle;
        end
        else if (terminal_count_pulse[k])
        begin
          tc_out[k] <= !tc_out[k];
        end
      end
      else
      begin
        // one clock behind the internal pulse, polarity applied
        tc_out[k] <= terminal_count_pulse[k] ^ ctrl[k].tc_polarity;
      end
    end
  end

  // ==========================================================
  // embedded auxiliary counter: pulse high then low time
  always_ff @(posedge clock)
  begin
    for (int k = 0; k < N; k++)
    begin
      if (sys_rst || start[k] || !ctrl[k].run
          || ctrl[k].mode != MODE_PULSE)
      begin
        aux[k]        <= '0;
        pulse_seen[k] <= 1'b0;
      end
      else if (armed[k] && rise[route[k].measured])
      begin
        // the edge cycle is already the first tick of the new phase
        aux[k]        <= 32'(!ctrl[k].timebase_ext
                             || rise[route[k].timebase]);
        pulse_seen[k] <= 1'b1;
      end
      else if (armed[k] && fall[route[k].measured])
      begin
        aux[k] <= 32'(!ctrl[k].timebase_ext
                      || rise[route[k].timebase]);
      end
      else if (!ctrl[k].timebase_ext || rise[route[k].timebase])
      begin
        aux[k] <= aux[k] + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // buffer filling and overflow
  always_comb
  begin
    for (int k = 0; k < N; k++)
    begin
      push[k]    = 1'b0;
      fifo_in[k] = count[k];
      if (ctrl[k].run && run_q[k] && armed[k])
      begin
        if (ctrl[k].mode == MODE_SAMPLE)
        begin
          // user-routed sample clock only
          push[k] = pick_edge(rise, fall, route[k].sample_clock,
                              ctrl[k].sample_edge);
        end
        else if (ctrl[k].mode == MODE_PULSE && pulse_seen[k])
        begin
          // high time on falling edge, low time on next rising edge
          push[k]    = rise[route[k].measured]
                     || fall[route[k].measured];
          fifo_in[k] = aux[k];
        end
      end
      pop[k] = done && avs_read && chan == 3'(k) && offs == OFF_FIFO;
    end
  end

  always_ff @(posedge clock)
  begin
    for (int k = 0; k < N; k++)
    begin
      if (sys_rst || start[k])
      begin
        overflow[k] <= 1'b0;
      end
      else if (push[k] && !fifo_ready[k])
      begin
        overflow[k] <= 1'b1;
      end
      else if (done && avs_write && chan == 3'(k)
               && offs == OFF_STATUS && avs_byteenable[0]
               && avs_writedata[ST_OVERFLOW])
      begin
        overflow[k] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // one buffer per counter
  for (genvar g = 0; g < N; g++)
  begin : g_fifo
    sample_fifo #(
      .WIDTH (COUNT_W),
      .DEPTH (DEPTH)
    ) u_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .flush     (start[g]),
      .in_valid  (push[g]),
      .in_ready  (fifo_ready[g]),
      .in_data   (fifo_in[g]),
      .out_valid (fifo_valid[g]),
      .out_ready (pop[g]),
      .out_data  (fifo_out[g]),
      .level     (fifo_lvl[g])
    );
  end

endmodule

`default_nettype wire

//--- bench/edge_counter_32_monitor.sv
`default_nettype none

module edge_counter_32_monitor (
  // clock and reset
  input wire logic                               clock,
  input wire logic                               sys_rst,
  // register bus
  input wire logic                               avs_read,
  input wire logic                               avs_write,
  input wire logic [31:0]                        avs_readdata,
  input wire logic                               avs_waitrequest,
  // routed signals
  input wire logic [counter_pkg::NUM_ROUTED-1:0] routed_in,
  input wire logic [counter_pkg::NUM_COUNTERS-1:0] tc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import counter_pkg::*;

  // ==========================================================
  // cycles since the last input change or accepted write
  logic [NUM_ROUTED-1:0] rt_q;
  logic [4:0]            since_evt;

  always_ff @(posedge clock)
  begin
    rt_q <= routed_in;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || routed_in != rt_q || (avs_write && !avs_waitrequest))
      since_evt <= 5'h0;
    else if (since_evt != 5'h1F)
      since_evt <= since_evt + 5'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // assertions
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_cause: assert property (!avs_waitrequest |->
      $past((avs_read || avs_write) && avs_waitrequest))
    else $error("answer without a taken request");
  a_wait_req: assert property (!avs_waitrequest |-> (avs_read || avs_write))
    else $error("answer while no request held");
  a_req_taken: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  a_bus_quiet: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer with no request");
  a_rd_hold: assert property ($changed(avs_readdata) |->
      $past(avs_read && avs_waitrequest))
    else $error("readdata changed without a read");
  a_reset_idle: assert property ($fell(sys_rst) |->
      avs_waitrequest && tc_out == '0 && avs_readdata == 32'h0000_0000)
    else $error("outputs not idle after reset");
  a_tc_cause: assert property ($changed(tc_out) |-> since_evt < 5'd16)
    else $error("terminal count moved with no cause");

  c_write: cover property (avs_write && !avs_waitrequest);
  c_read: cover property (avs_read && !avs_waitrequest);
  c_tc: cover property ($changed(tc_out));

endmodule

bind edge_counter_32 edge_counter_32_monitor u_edge_counter_32_monitor (
  .clock           (clock),
  .sys_rst         (sys_rst),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .routed_in       (routed_in),
  .tc_out          (tc_out)
);

`default_nettype wire

//--- bench/routed_source.sv
`default_nettype none

module routed_source (
  input  wire logic       clock,
  output logic [7:0]      routed_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial routed_in = 8'h00;

  // high held three clocks and low four, beyond the two the synchroniser needs
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      @(posedge clock) routed_in[idx] <= 1'b1;
      repeat (3) @(posedge clock);
      routed_in[idx] <= 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (3) @(posedge clock);
  endtask

  // direction and pause lines come only from here; sample clock and trigger lines use pulse
  task automatic level(input int idx, input logic v);
    @(posedge clock) routed_in[idx] <= v;
    repeat (4) @(posedge clock);
  endtask

endmodule

`default_nettype wire

//--- bench/edge_counter_32_test.sv
`default_nettype none

module edge_counter_32_test;
  timeunit 1ns;
  timeprecision 1ps;
  import counter_pkg::*;

  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  routed_in;
  logic [7:0]  tc_out;
  logic [7:0]  tc_prev = 8'h00;
  int          tc_rises = 0;
  int          failures = 0;
  int          cmp_count = 0;
  logic [31:0] d;

  edge_counter_32 u_edge_counter_32 (
    .clock (clock), .sys_rst (sys_rst), .avs_address (avs_address),
    .avs_read (avs_read), .avs_write (avs_write),
    .avs_writedata (avs_writedata), .avs_byteenable (avs_byteenable),
    .avs_readdata (avs_readdata), .avs_waitrequest (avs_waitrequest),
    .routed_in (routed_in), .tc_out (tc_out));

  routed_source u_routed_source (.clock (clock), .routed_in (routed_in));

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    tc_prev <= tc_out;
    if (tc_out[1] === 1'b1 && tc_prev[1] === 1'b0)
      tc_rises++;
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    // no cycle count assumed: only the watchdog ends a hung access
    do
    begin
      @(posedge clock);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input int k, input logic [4:0] off, input logic [31:0] v);
    logic [31:0] x;
    bus({k[2:0], off}, 1'b1, v, x);
  endtask

  task automatic rd_chk(input int k, input logic [4:0] off,
                        input logic [31:0] e);
    logic [31:0] x;
    bus({k[2:0], off}, 1'b0, 32'h0000_0000, x);
    chk("readback", e, x);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_defaults;
    for (int k = 0; k < NUM_COUNTERS; k += 7)
    begin
      rd_chk(k, OFF_CTRL, CTRL_RST);
      rd_chk(k, OFF_ROUTE, ROUTE_RST);
      rd_chk(k, OFF_INIT, INIT_RST);
      rd_chk(k, OFF_COUNT, 32'h0000_0000);
    end
    $display("test defaults done");
  endtask

  task automatic t_up_stop;
    wr(0, OFF_INIT, 32'h0000_0005);
    wr(0, OFF_CTRL, 32'h0000_0001);
    u_routed_source.pulse(0, 3);
    rd_chk(0, OFF_COUNT, 32'h0000_0008);
    wr(0, OFF_CTRL, 32'h0000_0000);
    rd_chk(0, OFF_COUNT, 32'h0000_0000);
    $display("test up and stop done");
  endtask

  task automatic t_down_wrap;
    wr(1, OFF_ROUTE, 32'h0000_0001);
    wr(1, OFF_INIT, 32'h0000_0002);
    wr(1, OFF_CTRL, 32'h0000_0019);
    u_routed_source.pulse(1, 3);
    rd_chk(1, OFF_COUNT, COUNT_MAX);
    $display("test down wrap done");
  endtask

  task automatic t_ext_dir;
    wr(2, OFF_ROUTE, 32'h0000_0020);
    wr(2, OFF_CTRL, 32'h0000_0021);
    u_routed_source.level(2, 1'b1);
    u_routed_source.pulse(0, 2);
    u_routed_source.level(2, 1'b0);
    u_routed_source.pulse(0, 1);
    rd_chk(2, OFF_COUNT, 32'h0000_0001);
    $display("test external direction done");
  endtask

  task automatic t_triggers;
    wr(3, OFF_ROUTE, 32'h0000_0300);
    wr(3, OFF_CTRL, 32'h0000_0041);
    wr(4, OFF_ROUTE, 32'h0000_4000);
    wr(4, OFF_CTRL, 32'h0000_0301);
    wr(5, OFF_ROUTE, 32'h0005_0000);
    wr(5, OFF_INIT, 32'h0000_0006);
    wr(5, OFF_RELOAD, 32'h0000_0003);
    wr(5, OFF_CTRL, 32'h0000_0401);
    u_routed_source.level(4, 1'b1);
    u_routed_source.pulse(0, 2);
    rd_chk(3, OFF_COUNT, 32'h0000_0000);
    rd_chk(4, OFF_COUNT, 32'h0000_0000);
    rd_chk(5, OFF_COUNT, 32'h0000_0008);
    u_routed_source.pulse(3, 1);
    u_routed_source.pulse(5, 1);
    u_routed_source.level(4, 1'b0);
    u_routed_source.pulse(0, 1);
    rd_chk(3, OFF_COUNT, 32'h0000_0001);
    rd_chk(4, OFF_COUNT, 32'h0000_0001);
    rd_chk(5, OFF_COUNT, 32'h0000_0004);
    $display("test triggers done");
  endtask

  task automatic t_sample;
    wr(6, OFF_ROUTE, 32'h0060_0000);
    wr(6, OFF_INIT, 32'h0000_0010);
    wr(6, OFF_CTRL, 32'h0000_0003);
    u_routed_source.pulse(0, 2);
    u_routed_source.pulse(6, 1);
    u_routed_source.pulse(0, 1);
    rd_chk(6, OFF_STATUS, 32'h0000_0103);
    rd_chk(6, OFF_FIFO, 32'h0000_0012);
    rd_chk(6, OFF_FIFO, 32'h0000_0000);
    rd_chk(6, OFF_COUNT, 32'h0000_0013);
    $display("test sample clock done");
  endtask

  task automatic t_cascade;
    wr(1, OFF_CTRL, 32'h0000_0000);
    wr(1, OFF_INIT, 32'hFFFF_FFFE);
    wr(7, OFF_ROUTE, 32'h0000_0009);
    wr(7, OFF_CTRL, 32'h0000_0001);
    wr(1, OFF_CTRL, 32'h0000_0001);
    tc_rises = 0;
    u_routed_source.pulse(1, 2);
    rd_chk(1, OFF_COUNT, 32'h0000_0000);
    rd_chk(7, OFF_COUNT, 32'h0000_0001);
    chk("tc pulses", 32'h0000_0001, 32'(tc_rises));
    $display("test cascade done");
  endtask

  task automatic t_tc_modes;
    // counter 7 keeps running; active-low pulse idles high
    wr(7, OFF_CTRL, 32'h0000_2001);
    rd_chk(7, OFF_STATUS, 32'h0000_000B);
    wr(1, OFF_CTRL, 32'h0000_5000);
    wr(1, OFF_INIT, 32'hFFFF_FFFE);
    wr(1, OFF_CTRL, 32'h0000_5001);
    chk("tc toggle idle", 32'h0000_0001, 32'(tc_out[1]));
    u_routed_source.pulse(1, 1);
    chk("tc toggled", 32'h0000_0000, 32'(tc_out[1]));
    rd_chk(7, OFF_COUNT, 32'h0000_0002);
    $display("test terminal count modes done");
  endtask

  task automatic t_pulse;
    // source pulses stand high three clocks, low four
    wr(4, OFF_CTRL, 32'h0000_0000);
    wr(4, OFF_ROUTE, 32'h0000_0000);
    wr(4, OFF_CTRL, 32'h0000_0005);
    u_routed_source.pulse(0, 2);
    rd_chk(4, OFF_FIFO, 32'h0000_0003);
    rd_chk(4, OFF_FIFO, 32'h0000_0004);
    rd_chk(4, OFF_COUNT, 32'h0000_0000);
    $display("test pulse measurement done");
  endtask

  // ==========================================================
  // verdict
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    t_defaults();
    t_up_stop();
    t_down_wrap();
    t_ext_dir();
    t_triggers();
    t_sample();
    t_cascade();
    t_tc_modes();
    t_pulse();
    give_verdict();
  end

endmodule

`default_nettype wire
